/* File: accum_exec_pkg.sv */
// shared types and constants for the accumulator execution unit
package accum_exec_pkg;

   // ****************************************
   // widths and reset values
   // ****************************************
   localparam int ACC_W = 16;
   localparam int BLK_W = 8;
   localparam int LEN_W = 16;
   localparam logic [15:0] ACC_RST = 16'h0000;
   localparam logic [7:0] BLK_RST = 8'h00;
   localparam logic [7:0] DB_FIRST_FREE = 8'h02;
   localparam logic [15:0] MEM_WORDS_RST = 16'h1000;
   localparam logic [7:0] TRANSFER_ERROR_CODE = 8'h01;
   localparam int STACK_DEPTH = 16;

   // ****************************************
   // operation codes
   // ****************************************
   typedef enum logic [4:0] {
      OP_NONE = 5'b00000,
      OP_LOAD = 5'b00001,
      OP_EQ = 5'b00010,
      OP_NE = 5'b00011,
      OP_GT = 5'b00100,
      OP_GE = 5'b00101,
      OP_LT = 5'b00110,
      OP_LE = 5'b00111,
      OP_ADD = 5'b01000,
      OP_SUB = 5'b01001,
      OP_CALL_ALWAYS = 5'b01010,
      OP_CALL_IF_TRUE = 5'b01011,
      OP_ACTIVATE_DB = 5'b01100,
      OP_CREATE_DB = 5'b01101,
      OP_BLOCK_FINISH = 5'b01110,
      OP_BLOCK_FINISH_ALWAYS = 5'b01111,
      OP_BLOCK_FINISH_IF_TRUE = 5'b10000
   } op_t;

   // instruction word from the sequencer
   typedef struct packed {
      op_t op;
      logic [15:0] operand;
   } instr_t;

   // condition code flags: cc1, cc0, overflow
   typedef struct packed {
      logic cc1;
      logic cc0;
      logic ovf;
   } cond_t;

   // sequencer directives
   typedef struct packed {
      logic call;
      logic ret;
      logic stop;
      logic err_block;
      logic [7:0] target;
      logic [7:0] stop_code;
   } seq_t;

endpackage

/* File: db_dir_mem.sv */
// data block directory: one length word per block number, registered read
`timescale 1ns/1ps
module db_dir_mem #(
   parameter int AW = 8,
   parameter int DW = 16
) (
   input wire logic core_clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [DW-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [DW-1:0] rdata_o
);

   logic [DW-1:0] mem [0:(1<<AW)-1];
   logic [DW-1:0] rdata_r;

   // ****************************************
   // storage, no reset so it maps to ram
   // ****************************************
   always_ff @(posedge core_clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_r <= mem[raddr_i];
   end

   assign rdata_o = rdata_r;

endmodule

/* File: accum_exec.sv */
// accumulator compare, arithmetic and block call execution unit
`timescale 1ns/1ps
module accum_exec
   import accum_exec_pkg::*;
#(
   parameter logic [15:0] MEM_WORDS = accum_exec_pkg::MEM_WORDS_RST,
   parameter logic [7:0] ERR_BLOCK = 8'h00
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire accum_exec_pkg::instr_t instr_i,
   input wire logic instr_valid_i,
   input wire logic err_block_en_i,
   input wire logic [15:0] load_data_i,
   output logic [15:0] primary_accumulator_o,
   output logic [15:0] secondary_accumulator_o,
   output logic logic_result_bit_o,
   output accum_exec_pkg::cond_t cond_o,
   output logic [7:0] active_db_o,
   output accum_exec_pkg::seq_t seq_o,
   output logic busy_o,
   output logic stopped_o
);
   import accum_exec_pkg::*;

   // ****************************************
   // helpers
   // ****************************************
   // signed compare of secondary against primary
   function automatic logic [1:0] sgn_cmp(input logic [15:0] a2, input logic [15:0] a1);
      logic [1:0] r;
      r = 2'b00;
      if ($signed(a2) > $signed(a1)) begin
         r = 2'b10;
      end else if ($signed(a2) < $signed(a1)) begin
         r = 2'b01;
      end
      return r;
   endfunction

   // numbers 0 and 1 are reserved; the 8-bit field caps at 255
   function automatic logic legal_db(input logic [7:0] n);
      return n >= DB_FIRST_FREE;
   endfunction

   // ****************************************
   // state
   // ****************************************
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_DB_LOOK = 2'b01,
      ST_DB_DECIDE = 2'b10,
      ST_STOP = 2'b11
   } state_t;

   state_t state_r, state_nxt;
   logic [15:0] acc1_r, acc1_nxt;
   logic [15:0] acc2_r, acc2_nxt;
   logic rlo_r, rlo_nxt;
   cond_t cc_r, cc_nxt;
   logic [7:0] adb_r, adb_nxt;
   seq_t seq_r, seq_nxt;
   logic [7:0] pend_db_r, pend_db_nxt;
   logic [15:0] free_r, free_nxt;
   logic dir_we;
   logic [7:0] dir_waddr;
   logic [15:0] dir_wdata;
   logic [15:0] dir_rdata;
   logic [7:0] dir_raddr;
   // status outputs registered from the next state, so they stand glitch free
   logic busy_r, busy_nxt;
   logic stop_r, stop_nxt;

   // ****************************************
   // arithmetic, wraps modulo 65536
   // ****************************************
   logic [16:0] sum_w, dif_w;
   logic add_ovf, sub_ovf;
   assign sum_w = {1'b0, acc2_r} + {1'b0, acc1_r};
   assign dif_w = {1'b0, acc2_r} - {1'b0, acc1_r};
   // overflow when operand signs imply a different result sign
   assign add_ovf = (acc2_r[15] == acc1_r[15]) && (sum_w[15] != acc1_r[15]);
   assign sub_ovf = (acc2_r[15] != acc1_r[15]) && (dif_w[15] != acc2_r[15]);

   // while a create runs, read the latched block number; the sequencer
   // may already show the next instruction word on its operand field
   assign dir_raddr = (state_r == ST_RUN) ? instr_i.operand[7:0] : pend_db_r;

   // directory of block lengths; zero means absent
   db_dir_mem #(
      .AW(BLK_W),
      .DW(LEN_W)
   ) u_dir (
      .core_clk_i(core_clk_i),
      .we_i(dir_we),
      .waddr_i(dir_waddr),
      .wdata_i(dir_wdata),
      .raddr_i(dir_raddr),
      .rdata_o(dir_rdata)
   );

   // ****************************************
   // next-state logic
   // ****************************************
   always_comb begin
      logic [1:0] rel;
      logic res;
      logic [15:0] need;
      rel = sgn_cmp(acc2_r, acc1_r);
      res = 1'b0;
      need = 16'h0000;
      state_nxt = state_r;
      acc1_nxt = acc1_r;
      acc2_nxt = acc2_r;
      rlo_nxt = rlo_r;
      cc_nxt = cc_r;
      adb_nxt = adb_r;
      pend_db_nxt = pend_db_r;
      free_nxt = free_r;
      seq_nxt = '0;
      dir_we = 1'b0;
      dir_waddr = pend_db_r;
      dir_wdata = acc1_r;
      case (state_r)
         ST_RUN: begin
            if (instr_valid_i) begin
               case (instr_i.op)
                  // load pushes the old primary into the secondary
                  OP_LOAD: begin
                     acc2_nxt = acc1_r;
                     acc1_nxt = load_data_i;
                  end
                  // comparisons run whatever the logic result bit is
                  OP_EQ, OP_NE, OP_GT, OP_GE, OP_LT, OP_LE: begin
                     case (instr_i.op)
                        OP_EQ: res = (acc2_r == acc1_r);
                        OP_NE: res = (acc2_r != acc1_r);
                        OP_GT: res = (rel == 2'b10);
                        OP_GE: res = (rel != 2'b01);
                        OP_LT: res = (rel == 2'b01);
                        OP_LE: res = (rel != 2'b10);
                        default: res = 1'b0;
                     endcase
                     rlo_nxt = res;
                     // cc1/cc0: 00 equal, 01 less, 10 greater
                     cc_nxt.cc1 = (rel == 2'b10);
                     cc_nxt.cc0 = (rel == 2'b01);
                     cc_nxt.ovf = 1'b0;
                     // accumulators untouched here
                  end
                  // sum and difference come from the shared adders above
                  OP_ADD, OP_SUB: begin
                     acc1_nxt = (instr_i.op == OP_ADD) ? sum_w[15:0] : dif_w[15:0];
                     // logic result bit left alone
                     cc_nxt.ovf = (instr_i.op == OP_ADD) ? add_ovf : sub_ovf;
                     cc_nxt.cc1 = ~acc1_nxt[15] && (acc1_nxt != 16'h0000);
                     cc_nxt.cc0 = acc1_nxt[15];
                  end
                  // call always: sequencer gets a one-cycle call pulse
                  OP_CALL_ALWAYS: begin
                     seq_nxt.call = 1'b1;
                     seq_nxt.target = instr_i.operand[7:0];
                  end
                  // conditional call: taken only on a one, bit then forced to one
                  OP_CALL_IF_TRUE: begin
                     seq_nxt.call = rlo_r;
                     seq_nxt.target = instr_i.operand[7:0];
                     rlo_nxt = 1'b1;
                  end
                  // later data word accesses use this block, no wait
                  OP_ACTIVATE_DB: begin
                     adb_nxt = instr_i.operand[7:0];
                  end
                  OP_CREATE_DB: begin
                     // reserved numbers are ignored outright
                     if (legal_db(instr_i.operand[7:0])) begin
                        pend_db_nxt = instr_i.operand[7:0];
                        state_nxt = ST_DB_LOOK;
                     end
                  end
                  // both plain finishes return, result bit passes up untouched
                  OP_BLOCK_FINISH, OP_BLOCK_FINISH_ALWAYS: begin
                     seq_nxt.ret = 1'b1;
                  end
                  // not taken on zero: bit set to one and the run goes on
                  OP_BLOCK_FINISH_IF_TRUE: begin
                     seq_nxt.ret = rlo_r;
                     rlo_nxt = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
         end
         // directory read is registered, wait one cycle
         ST_DB_LOOK: begin
            state_nxt = ST_DB_DECIDE;
         end
         ST_DB_DECIDE: begin
            state_nxt = ST_RUN;
            // data word count is stored length plus one
            need = acc1_r + 16'h0001;
            if (acc1_r == 16'h0000) begin
               // delete: memory stays dead until compression
               dir_we = 1'b1;
               dir_wdata = 16'h0000;
            end else if (dir_rdata != 16'h0000) begin
               dir_we = 1'b0;
            end else if (need > free_r || acc1_r == 16'hffff) begin
               // oversize: error block if enabled, otherwise stop with a code
               if (err_block_en_i) begin
                  seq_nxt.call = 1'b1;
                  seq_nxt.err_block = 1'b1;
                  seq_nxt.target = ERR_BLOCK;
               end else begin
                  seq_nxt.stop = 1'b1;
                  seq_nxt.stop_code = TRANSFER_ERROR_CODE;
                  state_nxt = ST_STOP;
               end
            end else begin
               dir_we = 1'b1;
               dir_wdata = acc1_r;
               free_nxt = free_r - need;
            end
         end
         ST_STOP: begin
            state_nxt = ST_STOP;
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase

      // busy covers both directory cycles of a create
      busy_nxt = (state_nxt == ST_DB_LOOK) || (state_nxt == ST_DB_DECIDE);
      // stop is left only through reset
      stop_nxt = (state_nxt == ST_STOP);
   end

   // ****************************************
   // registers
   // ****************************************
   // one register bank for all state except the directory memory, async reset to idle values
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r <= ST_RUN;
         acc1_r <= ACC_RST;
         acc2_r <= ACC_RST;
         rlo_r <= 1'b0;
         cc_r <= '0;
         adb_r <= BLK_RST;
         seq_r <= '0;
         pend_db_r <= BLK_RST;
         free_r <= MEM_WORDS;
         busy_r <= 1'b0;
         stop_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         acc1_r <= acc1_nxt;
         acc2_r <= acc2_nxt;
         rlo_r <= rlo_nxt;
         cc_r <= cc_nxt;
         adb_r <= adb_nxt;
         seq_r <= seq_nxt;
         pend_db_r <= pend_db_nxt;
         free_r <= free_nxt;
         busy_r <= busy_nxt;
         stop_r <= stop_nxt;
      end
   end

   // ****************************************
   // outputs, all from flip-flops
   // ****************************************
   // every output is a register, no decode after the flops
   assign primary_accumulator_o = acc1_r;
   assign secondary_accumulator_o = acc2_r;
   assign logic_result_bit_o = rlo_r;
   assign cond_o = cc_r;
   assign active_db_o = adb_r;
   assign seq_o = seq_r;
   assign busy_o = busy_r;
   assign stopped_o = stop_r;

endmodule

/* File: accum_exec_props.sv */
// assertion checker for the accumulator execution unit
`timescale 1ns/1ps
module accum_exec_props
   import accum_exec_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire accum_exec_pkg::instr_t instr_i,
   input wire logic instr_valid_i,
   input wire logic [15:0] load_data_i,
   input wire logic [15:0] primary_accumulator_o,
   input wire logic [15:0] secondary_accumulator_o,
   input wire logic logic_result_bit_o,
   input wire accum_exec_pkg::cond_t cond_o,
   input wire accum_exec_pkg::seq_t seq_o,
   input wire logic busy_o,
   input wire logic stopped_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   // ***********************************
   // helpers
   // ***********************************
   // refused instructions must leave no trace, so only taken ones count
   wire logic take = instr_valid_i && !busy_o && !stopped_o;
   op_t op;
   assign op = instr_i.op;
   wire logic cmp = take && op inside {[OP_EQ:OP_LE]};
   wire logic signed [15:0] p = primary_accumulator_o;
   wire logic signed [15:0] s = secondary_accumulator_o;
   wire logic logic_result_bit = logic_result_bit_o;
   sequence s_create;
      take && op == OP_CREATE_DB && instr_i.operand[7:0] > 8'h01;
   endsequence
   sequence s_busy_two;
      busy_o [*2] ##1 !busy_o;
   endsequence
   // ***********************************
   // properties
   // ***********************************
   a_cmp_keeps_accs: assert property (cmp |=> $stable(p) && $stable(s))
      else $error("compare changed an accumulator");
   a_eq_pattern: assert property (take && op == OP_EQ |=> logic_result_bit == (p == s))
      else $error("equal result wrong");
   a_ne_pattern: assert property (take && op == OP_NE |=> logic_result_bit == (p != s))
      else $error("not equal result wrong");
   a_gt_signed: assert property (take && op == OP_GT |=> logic_result_bit == (s > p))
      else $error("greater result wrong");
   a_le_signed: assert property (take && op == OP_LE |=> logic_result_bit == (s <= p))
      else $error("less or equal result wrong");
   a_cmp_cond: assert property (cmp |=> cond_o == {s > p, s < p, 1'b0})
      else $error("compare flags wrong");
   a_add_sum: assert property (take && op == OP_ADD |=>
      p == 16'($past(p) + $past(s)) && $stable(s)) else $error("sum wrong");
   a_sub_diff: assert property (take && op == OP_SUB |=>
      p == 16'($past(s) - $past(p))) else $error("difference wrong");
   a_arith_rlo: assert property (take && op inside {OP_ADD, OP_SUB} |=> $stable(logic_result_bit))
      else $error("arithmetic touched result bit");
   a_load_shift: assert property (take && op == OP_LOAD |=>
      s == $past(p) && p == $past(load_data_i)) else $error("load shift wrong");
   a_call_cond: assert property (take && op == OP_CALL_IF_TRUE |=>
      logic_result_bit && seq_o.call == $past(logic_result_bit)) else $error("conditional call wrong");
   a_call_always: assert property (take && op == OP_CALL_ALWAYS |=>
      seq_o.call && $stable(logic_result_bit)) else $error("unconditional call wrong");
   a_finish_ret: assert property (take && op inside {OP_BLOCK_FINISH, OP_BLOCK_FINISH_ALWAYS} |=>
      seq_o.ret && $stable(logic_result_bit)) else $error("block finish wrong");
   a_finish_cond: assert property (take && op == OP_BLOCK_FINISH_IF_TRUE |=>
      logic_result_bit && seq_o.ret == $past(logic_result_bit)) else $error("conditional finish wrong");
   a_create_busy: assert property (s_create |=> s_busy_two)
      else $error("create busy window wrong");
   a_stop_holds: assert property (stopped_o |=> stopped_o)
      else $error("stop state left");
endmodule

bind accum_exec accum_exec_props props_u (.core_clk_i, .rstn_i, .instr_i, .instr_valid_i,
   .load_data_i, .primary_accumulator_o, .secondary_accumulator_o, .logic_result_bit_o,
   .cond_o, .seq_o, .busy_o, .stopped_o);

/* File: tb_top.sv */
// self-checking testbench for the accumulator execution unit
`timescale 1ns/1ps
module tb_top;
   import accum_exec_pkg::*;
   logic core_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   instr_t instr_i = '0;
   logic instr_valid_i = 1'b0;
   logic err_block_en_i = 1'b0;
   logic [15:0] load_data_i = 16'h0000;
   logic [15:0] pri, sec;
   logic logic_result_bit, busy, stp, r;
   logic [7:0] adb;
   logic signed [15:0] s, p;
   logic [55:0] t;
   cond_t cond;
   seq_t seq;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [31:0] pairs[4] = '{32'h0005_0005, 32'h8000_7fff, 32'hffff_0001, 32'h0003_0002};
   logic [55:0] arith[4] = '{{OP_ADD, 16'h036c, 16'h029c, 16'h0608, 3'b100},
      {OP_ADD, 16'h7fff, 16'h0001, 16'h8000, 3'b011},
      {OP_SUB, 16'h8000, 16'h0001, 16'h7fff, 3'b101},
      {OP_SUB, 16'h0001, 16'h0001, 16'h0000, 3'b000}};
   // each entry: result bit before, then expected call, return, result bit
   op_t cops[10] = '{OP_CALL_IF_TRUE, OP_CALL_IF_TRUE, OP_CALL_ALWAYS, OP_CALL_ALWAYS,
      OP_ACTIVATE_DB, OP_ACTIVATE_DB, OP_BLOCK_FINISH, OP_BLOCK_FINISH_ALWAYS,
      OP_BLOCK_FINISH_IF_TRUE, OP_BLOCK_FINISH_IF_TRUE};
   logic [3:0] cexp[10] = '{4'b0001, 4'b1101, 4'b0100, 4'b1101, 4'b0000, 4'b1001,
      4'b0010, 4'b1011, 4'b0001, 4'b1011};

   accum_exec #(.ERR_BLOCK(8'h33)) dut_u (.core_clk_i, .rstn_i, .instr_i, .instr_valid_i,
      .err_block_en_i, .load_data_i, .primary_accumulator_o(pri),
      .secondary_accumulator_o(sec), .logic_result_bit_o(logic_result_bit), .cond_o(cond),
      .active_db_o(adb), .seq_o(seq), .busy_o(busy), .stopped_o(stp));

   // ***********************************
   // clock, timeout and tasks
   // ***********************************
   initial begin
      forever #50 core_clk_i = ~core_clk_i;
   end
   // a hung handshake must not stall the run
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fails++;
         summarize();
      end
   end
   task automatic chk(logic [39:0] got, logic [39:0] exp, string what);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // one instruction, results sampled just after the taking edge
   task automatic issue(op_t op, logic [15:0] opd, logic [15:0] ld = 16'h0000);
      @(posedge core_clk_i);
      instr_i <= '{op, opd};
      load_data_i <= ld;
      instr_valid_i <= 1'b1;
      @(posedge core_clk_i);
      instr_valid_i <= 1'b0;
      #1;
   endtask
   task automatic ld2(logic [15:0] a, logic [15:0] b);
      issue(OP_LOAD, 16'h0000, a);
      issue(OP_LOAD, 16'h0000, b);
   endtask
   task automatic set_rlo(logic b);
      ld2(16'h0005, 16'h0005);
      issue(b ? OP_EQ : OP_NE, 16'h0000);
   endtask
   // waits out the busy window; the outcome pulse is then visible
   task automatic create(logic [7:0] blk, logic [15:0] len);
      issue(OP_LOAD, 16'h0000, len);
      issue(OP_CREATE_DB, {8'h00, blk});
      for (int i = 0; i < 6 && busy === 1'b1; i++) @(posedge core_clk_i) #1;
   endtask
   function automatic logic rel(op_t op, logic signed [15:0] a, logic signed [15:0] b);
      case (op)
         OP_EQ: return a == b;
         OP_NE: return a != b;
         OP_GT: return a > b;
         OP_GE: return a >= b;
         OP_LT: return a < b;
         default: return a <= b;
      endcase
   endfunction
   task automatic summarize();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ***********************************
   // tests
   // ***********************************
   initial begin
      repeat (10) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      foreach (pairs[i]) begin
         {s, p} = pairs[i];
         ld2(s, p);
         chk({sec, pri}, pairs[i], "load");
         for (int j = 2; j < 8; j++) begin
            issue(op_t'(j), 16'h0000);
            chk(logic_result_bit, rel(op_t'(j), s, p), "compare");
            chk({sec, pri}, pairs[i], "accs kept");
            chk(cond, {s > p, s < p, 1'b0}, "compare flags");
         end
      end
      $display("test compare done");
      foreach (arith[i]) begin
         t = arith[i];
         set_rlo(i[0]);
         ld2(t[50:35], t[34:19]);
         r = logic_result_bit;
         issue(op_t'(t[55:51]), 16'h0000);
         chk({sec, pri, logic_result_bit}, {t[50:35], t[18:3], r}, "arith");
         chk(cond, t[2:0], "arith flags");
      end
      $display("test arithmetic done");
      foreach (cops[i]) begin
         set_rlo(cexp[i][3]);
         issue(cops[i], 16'h0040 + 16'(i));
         chk({seq.call, seq.ret, logic_result_bit}, cexp[i][2:0], "block ctl");
         if (cexp[i][2]) chk(seq.target, 8'h40 + 8'(i), "call target");
         if (cops[i] == OP_ACTIVATE_DB) chk(adb, 8'h40 + 8'(i), "active db");
      end
      $display("test block control done");
      create(8'h05, 16'h0000);
      create(8'h05, 16'h007f);
      chk({seq, stp}, '0, "create");
      create(8'h05, 16'hffff);
      chk({seq, stp}, '0, "existing");
      create(8'h01, 16'hffff);
      chk({seq, stp}, '0, "reserved");
      @(posedge core_clk_i);
      err_block_en_i <= 1'b1;
      create(8'h06, 16'h0000);
      create(8'h06, 16'hffff);
      chk({seq.call, seq.err_block, seq.stop, seq.target, stp}, 12'hc66, "err blk");
      @(posedge core_clk_i);
      err_block_en_i <= 1'b0;
      create(8'h07, 16'h0000);
      create(8'h07, 16'hffff);
      chk({seq.stop, seq.stop_code}, {1'b1, TRANSFER_ERROR_CODE}, "stop");
      issue(OP_LOAD, 16'h0000, 16'h1234);
      chk({stp, pri}, {1'b1, 16'hffff}, "stopped");
      // mid-run reset is the only way out of the stop state
      @(posedge core_clk_i);
      rstn_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      @(posedge core_clk_i) #1;
      chk({stp, busy, pri, sec, logic_result_bit, cond}, '0, "reset");
      issue(OP_LOAD, 16'h0000, 16'h0042);
      chk({sec, pri}, {16'h0000, 16'h0042}, "after reset");
      $display("test create done");
      summarize();
   end
endmodule
